// [marker_pkg.sv]
// Shared constants and types for the marker block compare/transfer engine
package marker_pkg;

  // ----------------------------------------------------------------
  // Marker memory geometry
  // ----------------------------------------------------------------
  localparam int MEM_BYTES = 384;
  localparam int XFER_UNITS = 32;
  localparam logic [17:0] MEM_END = 18'd384;
  localparam logic [17:0] BYTE_AREA_END = 18'd96;
  localparam logic [17:0] WORD_AREA_END = 18'd192;
  localparam logic [17:0] DWORD_AREA_END = 18'd384;
  localparam logic [15:0] COUNT_MIN = 16'd1;
  localparam logic [15:0] COUNT_MAX = 16'd383;
  localparam logic [15:0] DIRECT_MIN = 16'd1;
  localparam logic [15:0] DIRECT_MAX = 16'd96;
  localparam logic [15:0] OFFSET_MAX = 16'd383;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OPERAND_OFFSET = 2'b00,
    OPERAND_BYTE = 2'b01,
    OPERAND_WORD = 2'b10,
    OPERAND_DWORD = 2'b11
  } operand_e;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_COMPARE = 2'b01,
    ENG_TRANSFER = 2'b10
  } engine_e;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CMP_CTRL = 8'h00;
  localparam logic [7:0] REG_CMP_FIRST = 8'h04;
  localparam logic [7:0] REG_CMP_SECOND = 8'h08;
  localparam logic [7:0] REG_CMP_COUNT = 8'h0C;
  localparam logic [7:0] REG_CMP_STATUS = 8'h10;
  localparam logic [7:0] REG_XFER_SELECT = 8'h14;
  localparam logic [7:0] REG_XFER_SOURCE = 8'h18;
  localparam logic [7:0] REG_XFER_DEST = 8'h1C;
  localparam logic [7:0] REG_XFER_COUNT = 8'h20;
  localparam logic [7:0] REG_XFER_MODE = 8'h24;
  localparam logic [7:0] REG_XFER_TRIGGER = 8'h28;
  localparam logic [7:0] REG_XFER_STATUS = 8'h2C;
  localparam logic [7:0] REG_MEM_ADDR = 8'h30;
  localparam logic [7:0] REG_MEM_DATA = 8'h34;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int KIND_LSB = 16;
  localparam int STAT_EQUAL = 0;
  localparam int STAT_COUNT_ERR = 1;
  localparam int STAT_OVERLAP_ERR = 2;
  localparam int STAT_OFFSET_ERR = 3;
  localparam int STAT_BUSY = 4;
  localparam logic FILL_MODE = 1'b0;
  localparam logic COPY_MODE = 1'b1;
  localparam logic [1:0] RST_KIND = 2'b00;
  localparam logic [15:0] RST_VALUE = 16'h0000;
  localparam logic [15:0] RST_COUNT = 16'h0001;

endpackage

// [range_check.sv]
// Start address resolution and error checks for one pair of ranges
`timescale 1ns/1ps
module range_check
  import marker_pkg::*;
(
  input wire logic [1:0] a_kind,
  input wire logic [15:0] a_value,
  input wire logic [1:0] b_kind,
  input wire logic [15:0] b_value,
  input wire logic [15:0] count,
  input wire logic a_single,
  output logic [8:0] a_start,
  output logic [8:0] b_start,
  output logic count_error,
  output logic overlap_error,
  output logic offset_error
);

  // ----------------------------------------------------------------
  // Resolution helpers
  // ----------------------------------------------------------------
  function automatic logic [17:0] start_of(logic [1:0] k, logic [15:0] v);
    logic [17:0] vm1;
    vm1 = {2'b00, v} - 18'd1;
    unique case (k)
      OPERAND_BYTE: start_of = vm1;
      OPERAND_WORD: start_of = {vm1[16:0], 1'b0};
      OPERAND_DWORD: start_of = {vm1[15:0], 2'b00};
      default: start_of = {2'b00, v};
    endcase
  endfunction

  function automatic logic [17:0] area_end(logic [1:0] k);
    unique case (k)
      OPERAND_BYTE: area_end = BYTE_AREA_END;
      OPERAND_WORD: area_end = WORD_AREA_END;
      OPERAND_DWORD: area_end = DWORD_AREA_END;
      default: area_end = MEM_END;
    endcase
  endfunction

  function automatic logic bad_start(logic [1:0] k, logic [15:0] v);
    if (k == OPERAND_OFFSET) begin
      bad_start = v > OFFSET_MAX;
    end else begin
      bad_start = (v < DIRECT_MIN) || (v > DIRECT_MAX);
    end
  endfunction

  logic [17:0] sa;
  logic [17:0] sb;
  logic [17:0] len_a;
  logic [17:0] len_b;

  // Wide arithmetic so out-of-range inputs cannot wrap into a legal range
  always_comb begin
    sa = start_of(a_kind, a_value);
    sb = start_of(b_kind, b_value);
    len_a = a_single ? 18'd1 : {2'b00, count};
    len_b = {2'b00, count};
    offset_error = (count < COUNT_MIN) || (count > COUNT_MAX) ||
                   bad_start(a_kind, a_value) ||
                   bad_start(b_kind, b_value);
    count_error = (sa + len_a > area_end(a_kind)) ||
                  (sb + len_b > area_end(b_kind));
    overlap_error = (sa < sb + len_b) && (sb < sa + len_a);
    a_start = sa[8:0];
    b_start = sb[8:0];
  end

endmodule

// [marker_block_compare_transfer.sv]
// Marker memory block comparator and block transfer engine, Wishbone slave
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module marker_block_compare_transfer
  import marker_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic ranges_equal_flag,
  output logic compare_count_error,
  output logic compare_overlap_error,
  output logic compare_offset_error
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] marker_mem [0:MEM_BYTES-1];

  logic compare_enable_coil;
  logic [1:0] cmp_first_kind;
  logic [15:0] cmp_first_value;
  logic [1:0] cmp_second_kind;
  logic [15:0] cmp_second_value;
  logic [15:0] cmp_count;

  logic [4:0] xfer_select;
  logic [1:0] src_kind [0:XFER_UNITS-1];
  logic [15:0] src_value [0:XFER_UNITS-1];
  logic [1:0] dst_kind [0:XFER_UNITS-1];
  logic [15:0] dst_value [0:XFER_UNITS-1];
  logic [15:0] xfer_count [0:XFER_UNITS-1];
  logic [XFER_UNITS-1:0] xfer_mode;
  logic [XFER_UNITS-1:0] transfer_trigger_coil;
  logic [XFER_UNITS-1:0] trigger_prev;
  logic [XFER_UNITS-1:0] trigger_pending;
  logic [XFER_UNITS-1:0] transfer_range_error;
  logic [XFER_UNITS-1:0] transfer_overlap_error;
  logic [XFER_UNITS-1:0] transfer_offset_error;
  logic [8:0] mem_addr;

  engine_e state;
  logic [4:0] scan_ptr;
  logic [8:0] run_a;
  logic [8:0] run_b;
  logic [8:0] run_last;
  logic [8:0] run_idx;
  logic run_copy;

  // ----------------------------------------------------------------
  // Range checkers: one for the comparator, one for the scanned unit
  // ----------------------------------------------------------------
  logic [8:0] c_a_start;
  logic [8:0] c_b_start;
  logic c_count_err;
  logic c_overlap_err;
  logic c_offset_err;
  logic [8:0] t_a_start;
  logic [8:0] t_b_start;
  logic t_range_err;
  logic t_overlap_err;
  logic t_offset_err;
  logic c_any_err;
  logic t_any_err;

  range_check cmp_check (
    .a_kind(cmp_first_kind),
    .a_value(cmp_first_value),
    .b_kind(cmp_second_kind),
    .b_value(cmp_second_value),
    .count(cmp_count),
    .a_single(1'b0),
    .a_start(c_a_start),
    .b_start(c_b_start),
    .count_error(c_count_err),
    .overlap_error(c_overlap_err),
    .offset_error(c_offset_err)
  );

  range_check xfer_check (
    .a_kind(src_kind[scan_ptr]),
    .a_value(src_value[scan_ptr]),
    .b_kind(dst_kind[scan_ptr]),
    .b_value(dst_value[scan_ptr]),
    .count(xfer_count[scan_ptr]),
    .a_single(xfer_mode[scan_ptr] == FILL_MODE),
    .a_start(t_a_start),
    .b_start(t_b_start),
    .count_error(t_range_err),
    .overlap_error(t_overlap_err),
    .offset_error(t_offset_err)
  );

  assign c_any_err = c_count_err | c_overlap_err | c_offset_err;
  assign t_any_err = t_range_err | t_overlap_err | t_offset_err;

  // ----------------------------------------------------------------
  // Wishbone decode
  // ----------------------------------------------------------------
  logic [7:0] word_adr;
  logic mem_access;
  logic bus_take;
  logic bus_write;
  logic [31:0] lane_mask;
  logic [31:0] rd_value;

  // Memory port is shared with the engine, so hold off during transfers
  assign word_adr = {wb_adr_i[7:2], 2'b00};
  assign mem_access = (word_adr == REG_MEM_DATA);
  assign bus_take = wb_cyc_i & wb_stb_i & ~wb_ack_o &
                    ~(mem_access & (state == ENG_TRANSFER));
  assign bus_write = bus_take & wb_we_i;
  assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function automatic logic [31:0] merge(logic [31:0] old_v, logic [31:0] m,
                                        logic [31:0] d);
    merge = (old_v & ~m) | (d & m);
  endfunction

  function automatic logic [31:0] pack_op(logic [1:0] k, logic [15:0] v);
    pack_op = {14'h0000, k, v};
  endfunction

  // Read multiplexer; unmapped words read as zero
  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (word_adr)
      REG_CMP_CTRL: rd_value = {31'h0000_0000, compare_enable_coil};
      REG_CMP_FIRST: rd_value = pack_op(cmp_first_kind, cmp_first_value);
      REG_CMP_SECOND: rd_value = pack_op(cmp_second_kind, cmp_second_value);
      REG_CMP_COUNT: rd_value = {16'h0000, cmp_count};
      REG_CMP_STATUS: begin
        rd_value[STAT_EQUAL] = ranges_equal_flag;
        rd_value[STAT_COUNT_ERR] = compare_count_error;
        rd_value[STAT_OVERLAP_ERR] = compare_overlap_error;
        rd_value[STAT_OFFSET_ERR] = compare_offset_error;
        rd_value[STAT_BUSY] = (state != ENG_IDLE);
      end
      REG_XFER_SELECT: rd_value = {27'h000_0000, xfer_select};
      REG_XFER_SOURCE:
        rd_value = pack_op(src_kind[xfer_select], src_value[xfer_select]);
      REG_XFER_DEST:
        rd_value = pack_op(dst_kind[xfer_select], dst_value[xfer_select]);
      REG_XFER_COUNT: rd_value = {16'h0000, xfer_count[xfer_select]};
      REG_XFER_MODE: rd_value = {31'h0000_0000, xfer_mode[xfer_select]};
      REG_XFER_TRIGGER: rd_value = transfer_trigger_coil;
      REG_XFER_STATUS: begin
        rd_value[0] = transfer_range_error[xfer_select];
        rd_value[1] = transfer_overlap_error[xfer_select];
        rd_value[2] = transfer_offset_error[xfer_select];
        rd_value[3] = trigger_pending[xfer_select];
      end
      REG_MEM_ADDR: rd_value = {23'h00_0000, mem_addr};
      REG_MEM_DATA: rd_value = {24'h00_0000, marker_mem[mem_addr]};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  // Acknowledge and read data; ack drops the cycle after it is given
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_take;
      if (bus_take) begin
        wb_dat_o <= rd_value;
      end
    end
  end

  // ----------------------------------------------------------------
  // Comparator configuration, unit select, trigger and memory address registers
  // ----------------------------------------------------------------
  logic [31:0] w_first;
  logic [31:0] w_second;
  logic [31:0] w_count;

  assign w_first = merge(pack_op(cmp_first_kind, cmp_first_value),
                         lane_mask, wb_dat_i);
  assign w_second = merge(pack_op(cmp_second_kind, cmp_second_value),
                          lane_mask, wb_dat_i);
  assign w_count = merge({16'h0000, cmp_count}, lane_mask, wb_dat_i);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      compare_enable_coil <= 1'b0;
      cmp_first_kind <= RST_KIND;
      cmp_first_value <= RST_VALUE;
      cmp_second_kind <= RST_KIND;
      cmp_second_value <= RST_VALUE;
      cmp_count <= RST_COUNT;
      xfer_select <= 5'h00;
      mem_addr <= 9'h000;
      transfer_trigger_coil <= '0;
    end else if (bus_write) begin
      unique case (word_adr)
        REG_CMP_CTRL: if (wb_sel_i[0]) begin
          compare_enable_coil <= wb_dat_i[0];
        end
        REG_CMP_FIRST: begin
          cmp_first_kind <= w_first[KIND_LSB+1:KIND_LSB];
          cmp_first_value <= w_first[15:0];
        end
        REG_CMP_SECOND: begin
          cmp_second_kind <= w_second[KIND_LSB+1:KIND_LSB];
          cmp_second_value <= w_second[15:0];
        end
        REG_CMP_COUNT: cmp_count <= w_count[15:0];
        REG_XFER_SELECT: if (wb_sel_i[0]) begin
          xfer_select <= wb_dat_i[4:0];
        end
        REG_XFER_TRIGGER:
          transfer_trigger_coil <= merge(transfer_trigger_coil, lane_mask,
                                         wb_dat_i);
        REG_MEM_ADDR: mem_addr <= 9'(merge({23'h00_0000, mem_addr},
                                           lane_mask, wb_dat_i));
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Per-instance transfer parameters
  // ----------------------------------------------------------------
  logic [31:0] w_src;
  logic [31:0] w_dst;
  logic [31:0] w_xcount;

  assign w_src = merge(pack_op(src_kind[xfer_select], src_value[xfer_select]),
                       lane_mask, wb_dat_i);
  assign w_dst = merge(pack_op(dst_kind[xfer_select], dst_value[xfer_select]),
                       lane_mask, wb_dat_i);
  assign w_xcount = merge({16'h0000, xfer_count[xfer_select]}, lane_mask,
                          wb_dat_i);

  // Each unit keeps its own operands, count and mode
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < XFER_UNITS; i++) begin
        src_kind[i] <= RST_KIND;
        src_value[i] <= RST_VALUE;
        dst_kind[i] <= RST_KIND;
        dst_value[i] <= RST_VALUE;
        xfer_count[i] <= RST_COUNT;
      end
      xfer_mode <= {XFER_UNITS{FILL_MODE}};
    end else if (bus_write) begin
      unique case (word_adr)
        REG_XFER_SOURCE: begin
          src_kind[xfer_select] <= w_src[KIND_LSB+1:KIND_LSB];
          src_value[xfer_select] <= w_src[15:0];
        end
        REG_XFER_DEST: begin
          dst_kind[xfer_select] <= w_dst[KIND_LSB+1:KIND_LSB];
          dst_value[xfer_select] <= w_dst[15:0];
        end
        REG_XFER_COUNT: xfer_count[xfer_select] <= w_xcount[15:0];
        REG_XFER_MODE: if (wb_sel_i[0]) begin
          xfer_mode[xfer_select] <= wb_dat_i[0];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Trigger edges and per-unit error flags
  // ----------------------------------------------------------------
  logic start_xfer;
  logic drop_pending;

  assign drop_pending = (state == ENG_IDLE) & trigger_pending[scan_ptr];
  assign start_xfer = drop_pending & ~t_any_err;

  // A new edge wins over the clear of the same unit's pending bit
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      trigger_prev <= '0;
      trigger_pending <= '0;
    end else begin
      trigger_prev <= transfer_trigger_coil;
      for (int i = 0; i < XFER_UNITS; i++) begin
        if (transfer_trigger_coil[i] & ~trigger_prev[i]) begin
          trigger_pending[i] <= 1'b1;
        end else if (drop_pending && (scan_ptr == i[4:0])) begin
          trigger_pending[i] <= 1'b0;
        end
      end
    end
  end

  // Scan walks all units, refreshing errors whatever the trigger does
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scan_ptr <= 5'h00;
      transfer_range_error <= '0;
      transfer_overlap_error <= '0;
      transfer_offset_error <= '0;
    end else begin
      if (state == ENG_IDLE) begin
        scan_ptr <= scan_ptr + 5'h01;
      end
      transfer_range_error[scan_ptr] <= t_range_err;
      transfer_overlap_error[scan_ptr] <= t_overlap_err;
      transfer_offset_error[scan_ptr] <= t_offset_err;
    end
  end

  // Comparator errors refresh every cycle, enable or not
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      compare_count_error <= 1'b0;
      compare_overlap_error <= 1'b0;
      compare_offset_error <= 1'b0;
    end else begin
      compare_count_error <= c_count_err;
      compare_overlap_error <= c_overlap_err;
      compare_offset_error <= c_offset_err;
    end
  end

  // ----------------------------------------------------------------
  // Engine: transfers take priority over a new comparison pass
  // ----------------------------------------------------------------
  logic start_cmp;
  logic [8:0] addr_a;
  logic [8:0] addr_b;
  logic bytes_differ;

  assign start_cmp = ~start_xfer & compare_enable_coil & ~c_any_err;
  assign addr_a = run_copy ? 9'(run_a + run_idx) : run_a;
  assign addr_b = 9'(run_b + run_idx);
  assign bytes_differ = marker_mem[9'(run_a + run_idx)] != marker_mem[addr_b];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ENG_IDLE;
      run_a <= 9'h000;
      run_b <= 9'h000;
      run_last <= 9'h000;
      run_idx <= 9'h000;
      run_copy <= FILL_MODE;
      ranges_equal_flag <= 1'b0;
    end else begin
      unique case (state)
        ENG_IDLE: begin
          run_idx <= 9'h000;
          if (start_xfer) begin
            // Checks are already clean here, so memory is never half done
            run_a <= t_a_start;
            run_b <= t_b_start;
            run_last <= 9'(xfer_count[scan_ptr] - 16'd1);
            run_copy <= xfer_mode[scan_ptr];
            state <= ENG_TRANSFER;
          end else if (start_cmp) begin
            run_a <= c_a_start;
            run_b <= c_b_start;
            run_last <= 9'(cmp_count - 16'd1);
            run_copy <= COPY_MODE;
            state <= ENG_COMPARE;
          end
        end
        ENG_COMPARE: begin
          run_idx <= run_idx + 9'h001;
          if (bytes_differ) begin
            ranges_equal_flag <= 1'b0;
            state <= ENG_IDLE;
          end else if (run_idx == run_last) begin
            ranges_equal_flag <= 1'b1;
            state <= ENG_IDLE;
          end
        end
        ENG_TRANSFER: begin
          run_idx <= run_idx + 9'h001;
          if (run_idx == run_last) begin
            state <= ENG_IDLE;
          end
        end
        default: state <= ENG_IDLE;
      endcase
    end
  end
  // Flag is only written at the end of a pass, so it holds otherwise

  // ----------------------------------------------------------------
  // Marker memory write port
  // ----------------------------------------------------------------
  // Bus writes only land outside transfers, so there is no collision
  always_ff @(posedge ref_clk) begin
    if (state == ENG_TRANSFER) begin
      marker_mem[addr_b] <= marker_mem[addr_a];
    end else if (bus_write && mem_access && wb_sel_i[0]) begin
      marker_mem[mem_addr] <= wb_dat_i[7:0];
    end
  end

endmodule

// [marker_props.sv]
// Port checker for the marker compare/transfer engine
`timescale 1ns/1ps
module marker_props
  import marker_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic ranges_equal_flag,
  input wire logic compare_count_error,
  input wire logic compare_overlap_error,
  input wire logic compare_offset_error
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [2:0] errs;
  logic wr_ack;
  // Error levels and write acknowledge seen together
  assign errs = {compare_offset_error, compare_overlap_error,
    compare_count_error};
  assign wr_ack = wb_ack_o && wb_we_i;
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_needs_req: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
    else $error("ack without request");
  a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o &&
    wb_adr_i != REG_MEM_DATA |=> wb_ack_o) else $error("ack late");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i > 8'h37 |-> wb_dat_o == 32'h0) else $error("unmapped data");
  a_read_data_quiet: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved");
  a_status_flag: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == REG_CMP_STATUS &&
    $stable(ranges_equal_flag) |-> wb_dat_o[STAT_EQUAL] == ranges_equal_flag)
    else $error("status flag mismatch");
  a_flag_error_free: assert property (
    $changed(ranges_equal_flag) |-> $past(errs) == 3'h0)
    else $error("flag moved under error");
  a_errors_on_write: assert property (
    $past(rstn, 3) && !wr_ack && !$past(wr_ack) |-> $stable(errs))
    else $error("errors moved without write");
  // Main scenarios reached
  c_flag_rise: cover property ($rose(ranges_equal_flag));
  c_count_err: cover property ($rose(compare_count_error));
  c_unmapped: cover property (wb_ack_o && wb_adr_i > 8'h37);
endmodule

bind marker_block_compare_transfer marker_props u_props (
  .ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .ranges_equal_flag(ranges_equal_flag),
  .compare_count_error(compare_count_error),
  .compare_overlap_error(compare_overlap_error),
  .compare_offset_error(compare_offset_error)
);

// [scan_host.sv]
// Scan host model: classic Wishbone master and offset helpers
`timescale 1ns/1ps
module scan_host (
  input wire logic ref_clk,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat,
  input wire logic [31:0] dat_in,
  input wire logic ack
);
  // ----------------------------------------
  // Bus cycle
  // ----------------------------------------
  initial begin
    {cyc, stb, we, adr, sel, dat} = '0;
  end
  // Held until ack; on release adr and dat invert so stale values never match, we and sel keep their values
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    @(posedge ref_clk);
    while (ack !== 1'b1) @(posedge ref_clk);
    q = dat_in;
    cyc <= 1'b0;
    stb <= 1'b0;
    adr <= ~a;
    dat <= ~d;
    @(posedge ref_clk);
  endtask
  // Offsets from marker byte one
  function automatic logic [15:0] word_off(input logic [15:0] x);
    return (x - 16'h1) * 16'h2;
  endfunction
  function automatic logic [15:0] dword_off(input logic [15:0] x);
    return (x - 16'h1) * 16'h4;
  endfunction
endmodule

// [marker_block_compare_transfer_bench.sv]
// Self-checking bench for the marker compare/transfer engine
`timescale 1ns/1ps
module marker_block_compare_transfer_bench
  import marker_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc, stb, we, ack, eq, e_cnt, e_ovl, e_off;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rdat, q;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  always #50 ref_clk = ~ref_clk;
  marker_block_compare_transfer u_dut (.ref_clk(ref_clk), .rstn(rstn),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ranges_equal_flag(eq), .compare_count_error(e_cnt),
    .compare_overlap_error(e_ovl), .compare_offset_error(e_off));
  scan_host u_host (.ref_clk(ref_clk), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .dat(dat), .dat_in(rdat), .ack(ack));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic test_done;
    if (n_fail == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask
  task automatic put(input int i, input logic [7:0] v);
    wr(REG_MEM_ADDR, i);
    wr(REG_MEM_DATA, {24'h0, v});
  endtask
  task automatic peek(input int i, input logic [7:0] v);
    wr(REG_MEM_ADDR, i);
    u_host.xfer(1'b0, REG_MEM_DATA, 32'h0, q);
    chk(q, {24'h0, v});
  endtask
  // Error levels refresh one cycle after the last write
  task automatic cfg(input logic [17:0] a, input logic [17:0] b,
    input logic [15:0] n, input logic [2:0] e);
    wr(REG_CMP_FIRST, {14'h0, a});
    wr(REG_CMP_SECOND, {14'h0, b});
    wr(REG_CMP_COUNT, {16'h0, n});
    repeat (2) @(posedge ref_clk);
    chk({e_off, e_ovl, e_cnt}, e);
  endtask
  // Enable, wait up to 200 cycles for the flag to match, then check it; the engine stays enabled
  task automatic run_cmp(input logic v);
    wr(REG_CMP_CTRL, 32'h1);
    for (int i = 0; i < 200 && eq !== v; i++) @(posedge ref_clk);
    chk(eq, v);
  endtask
  // Trigger unit 31; the scanner may take 32 idle cycles to start it
  task automatic fire(input logic rearm);
    if (rearm) wr(REG_XFER_TRIGGER, 32'h0);
    wr(REG_XFER_TRIGGER, 32'h80000000);
    repeat (40) @(posedge ref_clk);
    q = 32'hF;
    for (int i = 0; i < 200 && q[3] !== 1'b0; i++)
      u_host.xfer(1'b0, REG_XFER_STATUS, 32'h0, q);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_compare;
    for (int k = 0; k < 5; k++) begin
      put(9 + k, 8'h40 + k[7:0]);
      put(39 + k, 8'h40 + k[7:0]);
      put(64 + k, 8'h40 + k[7:0]);
    end
    cfg({OPERAND_BYTE, 16'h000A}, {OPERAND_BYTE, 16'h0028}, 16'h5, 3'h0);
    run_cmp(1'b1);
    put(43, 8'h00);
    run_cmp(1'b0);
    wr(REG_CMP_CTRL, 32'h0);
    repeat (20) @(posedge ref_clk);
    cfg({OPERAND_BYTE, 16'h000A},
      {OPERAND_OFFSET, u_host.dword_off(16'h0011)}, 16'h4, 3'h0);
    run_cmp(1'b1);
    u_host.xfer(1'b0, REG_CMP_STATUS, 32'h0, q);
    chk(q & 32'hF, 32'h1);
    wr(REG_CMP_CTRL, 32'h0);
    repeat (20) @(posedge ref_clk);
  endtask
  task automatic t_errors;
    cfg({OPERAND_DWORD, 16'h003C}, {OPERAND_DWORD, 16'h005A},
      16'h001E, 3'h1);
    cfg({OPERAND_OFFSET, u_host.word_off(16'h003C)},
      {OPERAND_WORD, 16'h0040}, 16'h000C, 3'h2);
    cfg({OPERAND_BYTE, 16'h000A}, {OPERAND_BYTE, 16'h0028},
      16'h0000, 3'h4);
  endtask
  task automatic t_transfer;
    wr(REG_XFER_SELECT, 32'h1F);
    wr(REG_XFER_SOURCE, {14'h0, OPERAND_BYTE, 16'h000A});
    wr(REG_XFER_DEST, {14'h0, OPERAND_BYTE, 16'h0014});
    wr(REG_XFER_COUNT, 32'h5);
    fire(1'b1);
    chk(q, 32'h0);
    for (int k = 0; k < 5; k++) peek(19 + k, 8'h40);
    put(9, 8'h55);
    fire(1'b0);
    peek(19, 8'h40);
    wr(REG_XFER_MODE, 32'h1);
    wr(REG_XFER_COUNT, 32'h190);
    fire(1'b1);
    chk(q, 32'h7);
    peek(19, 8'h40);
    wr(REG_XFER_COUNT, 32'h5);
    fire(1'b1);
    for (int k = 0; k < 5; k++)
      peek(19 + k, k == 0 ? 8'h55 : 8'h40 + k[7:0]);
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    t_compare();
    t_errors();
    t_transfer();
    u_host.xfer(1'b0, 8'h3C, 32'h0, q);
    chk(q, 32'h0);
    test_done();
  end
endmodule
